/* File: sar_conv_regs.svh */
// Register offsets, field positions, vector codes and timing counts
`ifndef SAR_CONV_REGS_SVH
`define SAR_CONV_REGS_SVH

// =====================================================================
// Register word offsets
// =====================================================================
`define REG_CTRL0 8'h00
`define REG_CTRL1 8'h01
`define REG_PORT_SEL 8'h02
`define REG_FLAGS 8'h03
`define REG_IVEC 8'h04
`define REG_STATUS 8'h05
`define REG_MCTL_BASE 8'h10
`define REG_MEM_BASE 8'h20
`define REG_BLOCK_MASK 8'hF0

// =====================================================================
// Control register 0 fields
// =====================================================================
`define C0_START_BIT 0
`define C0_ENABLE_BIT 1
`define C0_POWER_BIT 4
`define C0_REF_ON_BIT 5
`define C0_REF_HIGH_BIT 6
`define C0_SHT_LSB 8
`define C0_SHT_MSB 11

// =====================================================================
// Control register 1 fields
// =====================================================================
`define C1_SHS_LSB 0
`define C1_SHS_MSB 1
`define C1_INV_BIT 2
`define C1_PULSE_BIT 3
`define C1_DIV_LSB 4
`define C1_DIV_MSB 6
`define C1_SSEL_LSB 7
`define C1_SSEL_MSB 8
`define C1_START_LSB 9
`define C1_START_MSB 12

// =====================================================================
// Status register fields
// =====================================================================
`define ST_BUSY_BIT 0
`define ST_OVERFLOW_BIT 1

// =====================================================================
// Vector codes and conversion figures
// =====================================================================
`define IV_NONE 6'h00
`define IV_OVERFLOW 6'h02
`define IV_MEM_BASE 6'h06
`define CONV_TICKS 4'hC
`define SAR_MSB_CODE 12'h800
`define SAMPLE_STEP 7'h04
`define CHANNEL_COUNT 5'h0C

`endif

/* File: sar_conv_pkg.sv */
// Types shared by the converter control and its result memory
package sar_conv_pkg;

    // =================================================================
    // Bus carrier
    // =================================================================
    typedef struct packed {
        logic [7:0] addr;   // Word address
        logic [15:0] wdata; // Write data
        logic we;           // Write strobe
        logic re;           // Read strobe
    } bus_req_t;

    // =================================================================
    // Sequencer states
    // =================================================================
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_SYNC,
        ST_CONVERT
    } conv_state_t;

    // =================================================================
    // Whole state of the control module
    // =================================================================
    typedef struct packed {
        logic power;             // converter_power_on
        logic enable;            // conversion_enable
        logic start;             // software_start_bit
        logic ref_on;            // reference_on
        logic ref_high;          // reference_high_level
        logic [3:0] sht;         // sample_time_select
        logic [1:0] shs;         // sample_source_select
        logic inv;               // sample_input_invert
        logic pulse;             // pulse_sample_select
        logic [2:0] div;         // conv_clock_divider
        logic [1:0] ssel;        // conv_clock_source_sel
        logic [3:0] start_addr;  // Active control entry
        logic [7:0] port_sel;    // port_function_select
        logic [15:0] flags;      // Result-written flags
        logic overflow;          // Unread result overwritten
        logic [15:0][3:0] mctl;  // Channel field per entry
        logic [7:0] sync1;       // First synchroniser stage
        logic [7:0] sync2;       // Second synchroniser stage
        logic clk_prev;          // Selected source, last cycle
        logic trig_prev;         // Trigger, last cycle
        logic [2:0] div_cnt;     // Divider count
        logic tick;              // Conversion clock pulse
        conv_state_t fsm;        // Sequencer state
        logic samp;              // sample_control
        logic [6:0] tcnt;        // Sampling timer
        logic [3:0] conv_cnt;    // Conversion tick count
        logic [11:0] code;       // Trial code to the DAC
        logic [3:0] chan;        // Channel now routed
        logic [11:0] switches;   // Multiplexer switch closes
    } ctrl_state_t;

    // =================================================================
    // Whole state of the result memory
    // =================================================================
    typedef struct packed {
        logic [15:0][11:0] words; // Stored results
        logic [15:0] rdata;       // Registered read word
    } mem_state_t;

endpackage : sar_conv_pkg

/* File: sar_result_mem.sv */
// Sixteen-word result store with a registered read port
`timescale 1ns/1ns
`default_nettype none

module sar_result_mem
    import sar_conv_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [11:0] wr_data_i,
    input wire logic rd_mem_i,
    input wire logic [3:0] rd_addr_i,
    input wire logic rd_load_i,
    input wire logic [15:0] aux_data_i,
    output logic [15:0] rdata_o
);

    // =================================================================
    // State
    // =================================================================
    mem_state_t st_reg; // Current state
    mem_state_t st_next; // Next state

    // Write port and read-word selection
    always_comb begin
        st_next = st_reg;
        if (wr_en_i) begin
            st_next.words[wr_addr_i] = wr_data_i;
        end
        // Read word stands one cycle only
        if (rd_mem_i) begin
            st_next.rdata = {4'h0, st_reg.words[rd_addr_i]};
        end else if (rd_load_i) begin
            st_next.rdata = aux_data_i;
        end else begin
            st_next.rdata = 16'h0000;
        end
    end

    // Register the state
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;

endmodule : sar_result_mem

`default_nettype wire

/* File: sar_adc_conversion_control.sv */
// Control logic of the twelve-bit successive-approximation converter
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

`include "sar_conv_regs.svh"

// Behaviour
// - Core runs only while power bit set
// - Configuration writes ignored while enable set
// - No sampling unless enable bit set
// - Four selectable conversion clock sources
// - Source divided by one to eight
// - Divided clock times conversion and pulse sampling
// - Stopped clock leaves conversion incomplete
// - Result saturates at both reference limits
// - Linear twelve-bit code zero to 4095
// - Sixteen result entries stored without software
// - Multiplexer picks one of twelve sources
// - Break before make, idle channels grounded
// - Function select disables shared pin buffers
// - Reference enable and level outputs
// - Rising trigger edge starts sampling
// - Two-bit field picks trigger source
// - Invert bit applied before edge detect
// - Sample high, fall starts 13-tick conversion
// - Pulse bit picks extended or timed sampling
// - Vector register encodes highest pending source
// - Extended mode: trigger drives sample, synchronised
// - Pulse mode: timer, multiples of four ticks
module sar_adc_conversion_control
    import sar_conv_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire bus_req_t bus_i,
    output logic [15:0] rdata_o,
    input wire logic sub_main_clk_i,
    input wire logic main_clk_i,
    input wire logic aux_clk_i,
    input wire logic internal_osc_i,
    input wire logic timer_a_out1_i,
    input wire logic timer_b_out0_i,
    input wire logic timer_b_out1_i,
    input wire logic comparator_i,
    output logic core_power_o,
    output logic reference_enable_o,
    output logic reference_high_o,
    output logic sample_control_o,
    output logic [11:0] dac_code_o,
    output logic [11:0] channel_switch_o,
    output logic [11:0] channel_ground_o,
    output logic [7:0] port_buffer_disable_o,
    output logic busy_o
);

    // =================================================================
    // Helper functions
    // =================================================================

    // Rising edge between two samples
    function automatic logic rise(input logic prev, input logic cur);
        rise = cur & ~prev;
    endfunction : rise

    // Channel code to switch pattern; unused codes close nothing
    function automatic logic [11:0] onehot12(input logic [3:0] ch);
        logic [11:0] res;
        res = 12'h000;
        if ({1'b0, ch} < `CHANNEL_COUNT) begin
            res[ch] = 1'b1;
        end
        onehot12 = res;
    endfunction : onehot12

    // Address falls into a sixteen-entry block
    function automatic logic in_block(input logic [7:0] a,
                                      input logic [7:0] base);
        in_block = ((a & `REG_BLOCK_MASK) == base);
    endfunction : in_block

    // =================================================================
    // State and internal signals
    // =================================================================
    ctrl_state_t st_reg; // Current state
    ctrl_state_t st_next; // Next state
    logic wr_en; // Result write this cycle
    logic [11:0] wr_data; // Result written
    logic rd_mem; // Read of a result entry
    logic rd_load; // Read of a control register
    logic [15:0] aux_data; // Control register read word
    logic [5:0] ivec; // Highest pending source code, up to 36
    logic clk_src; // Selected conversion clock source
    logic trig_src; // Selected, polarity-corrected trigger
    logic run; // Power and enable both set
    logic [15:0] flag_set; // Flags set this cycle
    logic [6:0] sample_len; // Pulse sampling length in ticks
    logic [15:0] mem_rdata; // Registered read word

    // =================================================================
    // Vector encoding
    // =================================================================

    // Lowest numbered pending source wins
    always_comb begin
        ivec = `IV_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (st_reg.flags[i]) begin
                ivec = `IV_MEM_BASE + 6'(2 * i);
            end
        end
        if (st_reg.overflow) begin
            ivec = `IV_OVERFLOW;
        end
    end

    // =================================================================
    // Register read words
    // =================================================================

    // Word for a control register read
    always_comb begin
        aux_data = 16'h0000;
        rd_mem = bus_i.re && in_block(bus_i.addr, `REG_MEM_BASE);
        rd_load = bus_i.re && !rd_mem;
        if (in_block(bus_i.addr, `REG_MCTL_BASE)) begin
            aux_data = {12'h000, st_reg.mctl[bus_i.addr[3:0]]};
        end else begin
            unique case (bus_i.addr)
                `REG_CTRL0: begin
                    aux_data[`C0_START_BIT] = st_reg.start;
                    aux_data[`C0_ENABLE_BIT] = st_reg.enable;
                    aux_data[`C0_POWER_BIT] = st_reg.power;
                    aux_data[`C0_REF_ON_BIT] = st_reg.ref_on;
                    aux_data[`C0_REF_HIGH_BIT] = st_reg.ref_high;
                    aux_data[`C0_SHT_MSB:`C0_SHT_LSB] = st_reg.sht;
                end
                `REG_CTRL1: begin
                    aux_data[`C1_SHS_MSB:`C1_SHS_LSB] = st_reg.shs;
                    aux_data[`C1_INV_BIT] = st_reg.inv;
                    aux_data[`C1_PULSE_BIT] = st_reg.pulse;
                    aux_data[`C1_DIV_MSB:`C1_DIV_LSB] = st_reg.div;
                    aux_data[`C1_SSEL_MSB:`C1_SSEL_LSB] = st_reg.ssel;
                    aux_data[`C1_START_MSB:`C1_START_LSB] =
                        st_reg.start_addr;
                end
                `REG_PORT_SEL: aux_data = {8'h00, st_reg.port_sel};
                `REG_FLAGS: aux_data = st_reg.flags;
                `REG_IVEC: aux_data = {10'h000, ivec};
                `REG_STATUS: begin
                    aux_data[`ST_BUSY_BIT] = (st_reg.fsm != ST_IDLE);
                    aux_data[`ST_OVERFLOW_BIT] = st_reg.overflow;
                end
                default: aux_data = 16'h0000;
            endcase
        end
    end

    // =================================================================
    // Clock source, trigger source and sample length
    // =================================================================

    // Synchronised copies, or the start bit, picked by the select fields
    always_comb begin
        unique case (st_reg.ssel)
            2'h0: clk_src = st_reg.sync2[3];
            2'h1: clk_src = st_reg.sync2[2];
            2'h2: clk_src = st_reg.sync2[1];
            2'h3: clk_src = st_reg.sync2[0];
        endcase
        unique case (st_reg.shs)
            2'h0: trig_src = st_reg.start;
            2'h1: trig_src = st_reg.sync2[4];
            2'h2: trig_src = st_reg.sync2[5];
            2'h3: trig_src = st_reg.sync2[6];
        endcase
        trig_src = trig_src ^ st_reg.inv;
        run = st_reg.power && st_reg.enable;
        sample_len = `SAMPLE_STEP * ({3'h0, st_reg.sht} + 7'h01);
    end

    // =================================================================
    // Next-state logic
    // =================================================================

    // Bus writes, divider, sequencer and multiplexer
    always_comb begin
        st_next = st_reg;
        wr_en = 1'b0;
        wr_data = st_reg.code;
        flag_set = 16'h0000;

        // Pins pass two flip-flops
        st_next.sync1 = {comparator_i, timer_b_out1_i, timer_b_out0_i,
                         timer_a_out1_i, internal_osc_i, aux_clk_i,
                         main_clk_i, sub_main_clk_i};
        st_next.sync2 = st_reg.sync1;

        // Divider makes one tick per div+1 source edges
        st_next.clk_prev = clk_src;
        st_next.tick = 1'b0;
        if (rise(st_reg.clk_prev, clk_src)) begin
            if (st_reg.div_cnt >= st_reg.div) begin
                st_next.div_cnt = 3'h0;
                st_next.tick = 1'b1;
            end else begin
                st_next.div_cnt = st_reg.div_cnt + 3'h1;
            end
        end
        st_next.trig_prev = trig_src;

        // Register writes
        if (bus_i.we) begin
            if (bus_i.addr == `REG_CTRL0) begin
                st_next.enable = bus_i.wdata[`C0_ENABLE_BIT];
                st_next.start = bus_i.wdata[`C0_START_BIT];
                if (!st_reg.enable) begin
                    st_next.power = bus_i.wdata[`C0_POWER_BIT];
                    st_next.ref_on = bus_i.wdata[`C0_REF_ON_BIT];
                    st_next.ref_high = bus_i.wdata[`C0_REF_HIGH_BIT];
                    st_next.sht = bus_i.wdata[`C0_SHT_MSB:`C0_SHT_LSB];
                end
            end else if (bus_i.addr == `REG_CTRL1 && !st_reg.enable) begin
                st_next.shs = bus_i.wdata[`C1_SHS_MSB:`C1_SHS_LSB];
                st_next.inv = bus_i.wdata[`C1_INV_BIT];
                st_next.pulse = bus_i.wdata[`C1_PULSE_BIT];
                st_next.div = bus_i.wdata[`C1_DIV_MSB:`C1_DIV_LSB];
                st_next.ssel = bus_i.wdata[`C1_SSEL_MSB:`C1_SSEL_LSB];
                st_next.start_addr =
                    bus_i.wdata[`C1_START_MSB:`C1_START_LSB];
            end else if (bus_i.addr == `REG_PORT_SEL) begin
                st_next.port_sel = bus_i.wdata[7:0];
            end else if (bus_i.addr == `REG_FLAGS) begin
                st_next.flags = st_reg.flags & ~bus_i.wdata;
            end else if (bus_i.addr == `REG_STATUS) begin
                if (bus_i.wdata[`ST_OVERFLOW_BIT]) begin
                    st_next.overflow = 1'b0;
                end
            end else if (in_block(bus_i.addr, `REG_MCTL_BASE) &&
                         !st_reg.enable) begin
                st_next.mctl[bus_i.addr[3:0]] = bus_i.wdata[3:0];
            end
        end
        // Reading a result clears its flag
        if (rd_mem) begin
            st_next.flags[bus_i.addr[3:0]] = 1'b0;
        end

        // Sequencer
        unique case (st_reg.fsm)
            ST_IDLE: begin
                st_next.samp = 1'b0;
                if (run && rise(st_reg.trig_prev, trig_src)) begin
                    st_next.fsm = ST_SAMPLE;
                    st_next.samp = 1'b1;
                    st_next.tcnt = 7'h00;
                end
            end
            ST_SAMPLE: begin
                if (!st_reg.pulse) begin
                    if (!trig_src) begin
                        st_next.samp = 1'b0;
                        st_next.fsm = ST_SYNC;
                    end
                end else if (st_reg.tick) begin
                    if (st_reg.tcnt + 7'h01 >= sample_len) begin
                        st_next.samp = 1'b0;
                        st_next.fsm = ST_CONVERT;
                        st_next.conv_cnt = 4'h0;
                        st_next.code = `SAR_MSB_CODE;
                    end else begin
                        st_next.tcnt = st_reg.tcnt + 7'h01;
                    end
                end
            end
            ST_SYNC: begin
                if (st_reg.tick) begin
                    st_next.fsm = ST_CONVERT;
                    st_next.conv_cnt = 4'h0;
                    st_next.code = `SAR_MSB_CODE;
                end
            end
            ST_CONVERT: begin
                // Only ticks advance; a stalled clock never finishes
                if (st_reg.tick) begin
                    if (st_reg.conv_cnt < `CONV_TICKS) begin
                        // Keep the trial bit while input is above it
                        if (!st_reg.sync2[7]) begin
                            st_next.code[4'hB - st_reg.conv_cnt] = 1'b0;
                        end
                        if (st_reg.conv_cnt < 4'hB) begin
                            st_next.code[4'hA - st_reg.conv_cnt] = 1'b1;
                        end
                        st_next.conv_cnt = st_reg.conv_cnt + 4'h1;
                    end else begin
                        // Thirteenth tick stores the code
                        wr_en = 1'b1;
                        flag_set[st_reg.start_addr] = 1'b1;
                        if (st_reg.flags[st_reg.start_addr]) begin
                            st_next.overflow = 1'b1;
                        end
                        st_next.fsm = ST_IDLE;
                    end
                end
            end
        endcase

        // Start bit clears itself at conversion start; a write wins
        if (st_reg.fsm != ST_CONVERT && st_next.fsm == ST_CONVERT &&
            !(bus_i.we && bus_i.addr == `REG_CTRL0)) begin
            st_next.start = 1'b0;
        end
        // Power or enable loss stops at once; no result unless the storing tick lands in that cycle
        if (!run) begin
            st_next.fsm = ST_IDLE;
            st_next.samp = 1'b0;
        end
        // Hardware set wins over any clear
        st_next.flags = st_next.flags | flag_set;

        // Break before make: open old switch, then close new one
        if (st_reg.chan != st_reg.mctl[st_reg.start_addr]) begin
            st_next.chan = st_reg.mctl[st_reg.start_addr];
            st_next.switches = 12'h000;
        end else if (st_next.samp) begin
            st_next.switches = onehot12(st_reg.chan);
        end else begin
            st_next.switches = 12'h000;
        end
    end

    // =================================================================
    // State register
    // =================================================================

    // Clock enable freezes everything
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // =================================================================
    // Result memory
    // =================================================================
    sar_result_mem u_mem (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .wr_en_i(wr_en),
        .wr_addr_i(st_reg.start_addr),
        .wr_data_i(wr_data),
        .rd_mem_i(rd_mem),
        .rd_addr_i(bus_i.addr[3:0]),
        .rd_load_i(rd_load),
        .aux_data_i(aux_data),
        .rdata_o(mem_rdata)
    );

    // =================================================================
    // Outputs, all from flip-flops
    // =================================================================
    assign rdata_o = mem_rdata;
    assign core_power_o = st_reg.power;
    assign reference_enable_o = st_reg.ref_on;
    assign reference_high_o = st_reg.ref_high;
    assign sample_control_o = st_reg.samp;
    assign dac_code_o = st_reg.code;
    assign channel_switch_o = st_reg.switches;
    assign channel_ground_o = ~st_reg.switches;
    assign port_buffer_disable_o = st_reg.port_sel;
    assign busy_o = (st_reg.fsm != ST_IDLE);

endmodule : sar_adc_conversion_control

`default_nettype wire

/* File: sar_conv_chk.sv */
// Port checker for the converter control
`timescale 1ns/1ns
`default_nettype none
`include "sar_conv_regs.svh"
module sar_conv_chk
    import sar_conv_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire bus_req_t bus_i,
    input wire logic core_power_o,
    input wire logic sample_control_o,
    input wire logic [11:0] channel_switch_o,
    input wire logic [11:0] channel_ground_o,
    input wire logic [7:0] port_buffer_disable_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_ground_inv: assert property (
        channel_ground_o == ~channel_switch_o) else $error("ground");
    a_one_switch: assert property (
        $onehot0(channel_switch_o)) else $error("switch");
    a_break_make: assert property (
        (|channel_switch_o) && $past(|channel_switch_o)
        |-> $stable(channel_switch_o)) else $error("break");
    a_switch_idle: assert property (
        !sample_control_o && !$past(sample_control_o)
        |-> channel_switch_o == 12'h000) else $error("open");
    a_sample_busy: assert property (
        sample_control_o |-> busy_o) else $error("busy");
    a_power_idle: assert property (
        !core_power_o && !$past(core_power_o) |-> !busy_o) else $error("off");
    a_power_src: assert property (
        $changed(core_power_o) |-> $past(ce_i && bus_i.we
        && bus_i.addr == `REG_CTRL0)) else $error("power");
    a_port_mirror: assert property (
        ce_i && bus_i.we && bus_i.addr == `REG_PORT_SEL
        |=> port_buffer_disable_o == $past(bus_i.wdata[7:0])) else $error("port");
    c_sample: cover property ($rose(sample_control_o));
    c_done: cover property ($fell(busy_o));
    c_switch: cover property (|channel_switch_o);
endmodule : sar_conv_chk
bind sar_adc_conversion_control sar_conv_chk chk (.clk_i, .reset_i, .ce_i,
    .bus_i, .core_power_o, .sample_control_o, .channel_switch_o,
    .channel_ground_o, .port_buffer_disable_o, .busy_o);
`default_nettype wire

/* File: sar_analog_model.sv */
// Analog side: channel levels, held sample, comparator, source clock
`timescale 1ns/1ns
`default_nettype none
module sar_analog_model (
    input wire logic clk_i,
    input wire logic [11:0][11:0] level_i,
    input wire logic [11:0] switch_i,
    input wire logic [11:0] dac_i,
    output logic cmp_o,
    output logic src_o
);
    logic [11:0] held = 12'h000; // Voltage on the sample capacitor
    logic [1:0] div = 2'h0; // Free source clock, four cycles a period
    // Capacitor tracks only the closed channel
    always @(posedge clk_i) begin
        for (int i = 0; i < 12; i++) if (switch_i[i]) held <= level_i[i];
        div <= div + 2'h1;
    end
    assign src_o = div[1];
    assign cmp_o = held >= dac_i;
endmodule : sar_analog_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the converter control
`timescale 1ns/1ns
`default_nettype none
`include "sar_conv_regs.svh"
module tb;
    import sar_conv_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    bus_req_t bus = '0;
    logic [2:0] tmr = 3'h0; // Timer trigger levels
    logic [11:0][11:0] lvl = '0; // Channel levels
    logic [15:0] rd_w;
    logic pwr, ren, rhi, samp, busy, cmp, src;
    logic [11:0] dac, sw, seen;
    logic [7:0] pbd;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 clk_i = ~clk_i;
    sar_adc_conversion_control uut (.clk_i, .reset_i, .ce_i(1'b1),
        .bus_i(bus), .rdata_o(rd_w), .sub_main_clk_i(src), .main_clk_i(src),
        .aux_clk_i(src), .internal_osc_i(src), .timer_a_out1_i(tmr[0]),
        .timer_b_out0_i(tmr[1]), .timer_b_out1_i(tmr[2]), .comparator_i(cmp),
        .core_power_o(pwr), .reference_enable_o(ren), .reference_high_o(rhi),
        .sample_control_o(samp), .dac_code_o(dac), .channel_switch_o(sw),
        .channel_ground_o(), .port_buffer_disable_o(pbd), .busy_o(busy));
    sar_analog_model far (.clk_i, .level_i(lvl), .switch_i(sw), .dac_i(dac),
        .cmp_o(cmp), .src_o(src));
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_i);
        bus.we <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [15:0] e, string n);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge clk_i);
        bus.re <= 1'b0;
        #1 chk(n, e, rd_w);
    endtask : rd
    task automatic conv(int s, int e, int c, int v);
        int inv, r, cfg, p;
        inv = (s != 0) ? $urandom % 2 : 0;
        r = ($urandom % 4) << 5;
        p = $urandom % 256;
        cfg = s | inv << 2 | 8 | ($urandom % 8) << 4 | ($urandom % 4) << 7 | e << 9;
        lvl[c] <= 12'(v);
        if (s != 0) tmr[s - 1] <= 1'(inv);
        wr(`REG_PORT_SEL, 16'(p));
        #1 chk("port", 16'(p), pbd);
        wr(`REG_CTRL0, 16'(16'h0011 | r));
        wr(`REG_MCTL_BASE + 8'(e), 16'(c));
        chk("busy", 0, busy);
        wr(`REG_CTRL1, 16'(cfg));
        wr(`REG_CTRL0, 16'(16'h0012 | r));
        wr(`REG_CTRL1, 16'(cfg ^ 16'h1E0C));
        if (s == 0) wr(`REG_CTRL0, 16'(16'h0013 | r));
        else tmr[s - 1] <= 1'(~inv);
        seen = 12'h000;
        for (int i = 0; i < 3000 && (i < 8 || busy); i++) begin
            @(posedge clk_i);
            if (samp && sw != 0) seen = sw;
        end
        chk("switch", 16'(1 << c), seen);
        chk("busy", 0, busy);
        chk("ref", 16'(r >> 5), {rhi, ren});
        chk("power", 1, pwr);
        rd(`REG_IVEC, 16'(6 + 2 * e), "vector");
        rd(`REG_FLAGS, 16'(1 << e), "flags");
        rd(`REG_MEM_BASE + 8'(e), 16'(v), "result");
        rd(`REG_FLAGS, 0, "flags");
    endtask : conv
    task automatic finish_test();
        if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // Cycle ceiling cuts a hang short
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'hAEFC));
        for (int i = 0; i < 12; i++) lvl[i] = 12'($urandom);
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(8'h07, 0, "unmapped");
        rd(`REG_CTRL0, 0, "ctrl0");
        for (int k = 0; k < 12; k++) begin
            conv(k % 4, $urandom % 16, k, k < 2 ? k * 4095 : $urandom % 4096);
        end
        finish_test();
    end
endmodule : tb
`default_nettype wire
